/* src/serp_status_report.sv */
// Status byte, three error flag registers, the register report sequence
// and the standby, wake and low-battery shutdown control.
// Assumes the loop interface decodes commands into one-cycle strobes and
// requests one register per input transfer strobe.
// Operation
// - Report queues status then three error registers.
// - Report exposes 24 registers; 20 extra.
// - Status byte clears once returned first.
// - Error registers clear after all four read.
// - Register value is binary weighted byte.
// - Any recorded error sets abnormal bit 5.
// - Status byte bit layout fixed, bit7 zero.
// - Command error register bit layout fixed.
// - Illegal command sets syntax bit and abnormal.
// - Hardware fault register bit layout fixed.
// - Calibration fault register bit layout fixed.
// - Standby first saves channel configuration.
// - Standby holds relays, floats outputs, stops totalize.
// - Any loop traffic wakes from standby.
// - Wake compares configuration; mismatch forces self-test.
// - Low battery sets bits 6,5,4, lights indicator.
// - Three minutes later open relays, power down.
// - After battery shutdown ignore wake until power cycle.
// - Service bit follows mask match on lower bits.
// - Low-battery bit cleared only by power cycle.
`timescale 1ns/10ps
`default_nettype none
module serp_status_report #(
  parameter int unsigned CFG_WIDTH = 32,
  parameter int unsigned RELAY_WIDTH = 32,
  parameter int unsigned DOUT_WIDTH = 16,
  parameter longint unsigned SHUTDOWN_CYCLES = serp_pkg::LOWBAT_CYCLES
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // Decoded commands from the loop interface
  input wire logic REPORT_REGISTERS_CMD_IN,
  input wire logic INPUT_TRANSFER_IN,
  input wire logic STATUS_POLL_CMD_IN,
  input wire logic STANDBY_CMD_IN,
  input wire logic WAKE_CMD_IN,
  input wire logic LOOP_ACTIVITY_IN,
  input wire logic ILLEGAL_CMD_IN,
  // Event sources
  input wire logic [7:0] CMD_ERROR_SET_IN,
  input wire logic [7:0] HW_FAULT_SET_IN,
  input wire logic [7:0] CAL_FAULT_SET_IN,
  input wire logic DATA_READY_SET_IN,
  input wire logic DATA_READY_CLR_IN,
  input wire logic MONITOR_EVENT_IN,
  input wire logic SELFTEST_FAIL_IN,
  input wire logic LOW_BATTERY_IN,
  input wire logic [7:0] SERVICE_MASK_IN,
  input wire logic [8*serp_pkg::EXTRA_REGS-1:0] EXTRA_REGS_IN,
  // Configuration and outputs under standby control
  input wire logic [CFG_WIDTH-1:0] CHANNEL_CONFIG_IN,
  input wire logic [RELAY_WIDTH-1:0] RELAY_CMD_IN,
  input wire logic [DOUT_WIDTH-1:0] DOUT_CMD_IN,
  input wire logic TOTALIZE_CMD_IN,
  // Report answer
  output logic [7:0] REPORT_DATA_OUT,
  output logic REPORT_VALID_OUT,
  output logic [7:0] STATUS_BYTE_OUT,
  // Power state
  output logic STANDBY_OUT,
  output logic SHUTDOWN_OUT,
  output logic SELFTEST_RESET_OUT,
  output logic ERROR_LED_OUT,
  output logic [RELAY_WIDTH-1:0] RELAY_OUT,
  output logic [DOUT_WIDTH-1:0] DOUT_OUT,
  output logic [DOUT_WIDTH-1:0] DOUT_OE_N_OUT,
  output logic TOTALIZE_OUT
);
  localparam int unsigned EXTRA_W = 8 * serp_pkg::EXTRA_REGS;
  localparam int unsigned TMR_W = 36;

  typedef enum logic [1:0] {
    SERP_RUN,
    SERP_STANDBY,
    SERP_DEAD
  } serp_pwr_t;

  typedef struct packed {
    serp_pwr_t pwr;
    logic [7:0] status;
    logic [7:0] gen_err;
    logic [7:0] hw_err;
    logic [7:0] cal_err;
    logic active;
    logic [4:0] idx;
    logic [7:0] data;
    logic valid;
    logic lowbat;
    logic [CFG_WIDTH-1:0] saved_cfg;
    logic [RELAY_WIDTH-1:0] relays;
    logic [DOUT_WIDTH-1:0] dout;
    logic dout_float;
    logic totalize;
    logic selftest_rst;
  } serp_state_t;

  serp_state_t st_reg;
  serp_state_t st_next;
  logic tmr_running;
  logic tmr_done;
  logic tmr_start;

  // Selects one byte of the report; the extra registers follow the four.
  // Bit 7 of the command and calibration flags is undefined and reads 0.
  function automatic logic [7:0] pick(input serp_state_t s,
                                      input logic [4:0] i,
                                      input logic [EXTRA_W-1:0] ex);
    logic [7:0] r;
    r = 8'h00;
    case (i)
      5'h00: r = s.status & serp_pkg::STATUS_USED;
      5'h01: r = s.gen_err & 8'h7f;
      5'h02: r = s.hw_err;
      5'h03: r = s.cal_err & 8'h7f;
      default: r = ex[8*(i-5'h04) +: 8];
    endcase
    return r;
  endfunction : pick

  // True when the report pointer stands on register n.
  function automatic logic at_reg(input logic [4:0] i,
                                  input int unsigned n);
    return i == 5'(n);
  endfunction : at_reg

  // Held while the battery is low, and dropped on the done cycle so that
  // the timer does not rearm on the edge that enters shutdown.
  assign tmr_start = st_reg.lowbat && (st_reg.pwr != SERP_DEAD)
    && !tmr_done;

  // Three-minute timer; its long count stays a parameter for simulation.
  serp_timer #(
    .WIDTH(TMR_W)
  ) u_timer (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .start_in(tmr_start),
    .count_in(TMR_W'(SHUTDOWN_CYCLES)),
    .running_out(tmr_running),
    .done_out(tmr_done)
  );

  always_comb
  begin
    logic any_err;
    logic [7:0] mask_hit;
    logic awake;
    logic traffic;
    any_err = 1'b0;
    mask_hit = 8'h00;
    awake = 1'b0;
    traffic = 1'b0;
    st_next = st_reg;
    st_next.valid = 1'b0;
    st_next.selftest_rst = 1'b0;
    awake = st_reg.pwr == SERP_RUN;
    // Activity, wake, report, transfer and poll strobes count as traffic that ends standby.
    traffic = LOOP_ACTIVITY_IN || WAKE_CMD_IN || REPORT_REGISTERS_CMD_IN
      || INPUT_TRANSFER_IN || STATUS_POLL_CMD_IN;

    // Clears first, so that events of the same cycle win.
    if (awake && STATUS_POLL_CMD_IN)
    begin
      st_next.status[serp_pkg::ST_READY] = 1'b0;
      st_next.status[serp_pkg::ST_POR] = 1'b0;
      st_next.status[serp_pkg::ST_EVENT] = 1'b0;
      st_next.status[serp_pkg::ST_ABNORMAL] = 1'b0;
    end
    if (DATA_READY_CLR_IN)
    begin
      st_next.status[serp_pkg::ST_READY] = 1'b0;
    end

    // Report sequencing, one register per input transfer.
    if (awake && REPORT_REGISTERS_CMD_IN)
    begin
      st_next.active = 1'b1;
      st_next.idx = 5'h00;
    end
    else if (awake && st_reg.active && INPUT_TRANSFER_IN)
    begin
      st_next.data = pick(st_reg, st_reg.idx, EXTRA_REGS_IN);
      st_next.valid = 1'b1;
      if (at_reg(st_reg.idx, 0))
      begin
        st_next.status = 8'h00;
      end
      // A report cut short before the fourth read leaves all three error registers set.
      if (at_reg(st_reg.idx, serp_pkg::ERROR_REGS - 1))
      begin
        st_next.gen_err = serp_pkg::FLAGS_RESET;
        st_next.hw_err = serp_pkg::FLAGS_RESET;
        st_next.cal_err = serp_pkg::FLAGS_RESET;
      end
      if (at_reg(st_reg.idx, serp_pkg::REPORT_LEN - 1))
      begin
        st_next.active = 1'b0;
      end
      else
      begin
        st_next.idx = st_reg.idx + 5'h01;
      end
    end

    // Event capture.
    st_next.gen_err = st_next.gen_err | CMD_ERROR_SET_IN;
    if (ILLEGAL_CMD_IN)
    begin
      st_next.gen_err[serp_pkg::GE_SYNTAX] = 1'b1;
    end
    st_next.hw_err = st_next.hw_err | HW_FAULT_SET_IN;
    st_next.cal_err = st_next.cal_err | CAL_FAULT_SET_IN;
    if (DATA_READY_SET_IN)
    begin
      st_next.status[serp_pkg::ST_READY] = 1'b1;
    end
    if (MONITOR_EVENT_IN)
    begin
      st_next.status[serp_pkg::ST_EVENT] = 1'b1;
    end
    if (SELFTEST_FAIL_IN)
    begin
      st_next.status[serp_pkg::ST_SELFTEST] = 1'b1;
    end
    any_err = ILLEGAL_CMD_IN || SELFTEST_FAIL_IN
      || (|CMD_ERROR_SET_IN) || (|HW_FAULT_SET_IN) || (|CAL_FAULT_SET_IN);
    if (any_err)
    begin
      st_next.status[serp_pkg::ST_ABNORMAL] = 1'b1;
    end

    // Low battery is sticky until the power cycle resets the block.
    if (LOW_BATTERY_IN)
    begin
      st_next.lowbat = 1'b1;
    end
    if (st_next.lowbat)
    begin
      st_next.status[serp_pkg::ST_LOWBAT] = 1'b1;
      st_next.status[serp_pkg::ST_ABNORMAL] = 1'b1;
    end

    // Service request follows the mask; low battery forces it on.
    mask_hit = st_next.status & SERVICE_MASK_IN & serp_pkg::MASKABLE;
    st_next.status[serp_pkg::ST_SERVICE] = (|mask_hit)
      || st_next.lowbat;
    st_next.status[7] = 1'b0;

    // Power control.
    // Relays load only while running, so standby holds them as they were.
    case (st_reg.pwr)
      SERP_RUN:
      begin
        st_next.relays = RELAY_CMD_IN;
        st_next.dout = DOUT_CMD_IN;
        st_next.dout_float = 1'b0;
        st_next.totalize = TOTALIZE_CMD_IN;
        if (STANDBY_CMD_IN)
        begin
          st_next.saved_cfg = CHANNEL_CONFIG_IN;
          st_next.pwr = SERP_STANDBY;
          st_next.dout_float = 1'b1;
          st_next.totalize = 1'b0;
        end
      end
      SERP_STANDBY:
      begin
        // Relays keep their values because nothing reloads them here.
        st_next.dout_float = 1'b1;
        st_next.totalize = 1'b0;
        if (traffic)
        begin
          st_next.pwr = SERP_RUN;
          st_next.dout_float = 1'b0;
          if (CHANNEL_CONFIG_IN != st_reg.saved_cfg)
          begin
            st_next.selftest_rst = 1'b1;
            st_next.active = 1'b0;
            // The forced reset path reports itself like a power-on reset.
            st_next.status[serp_pkg::ST_POR] = 1'b1;
          end
        end
      end
      SERP_DEAD:
      begin
        // Only RST_IN, the line power cycle, leaves this state.
        st_next.relays = '0;
        st_next.dout_float = 1'b1;
        st_next.totalize = 1'b0;
        st_next.active = 1'b0;
      end
      default:
      begin
        st_next.pwr = SERP_RUN;
      end
    endcase

    if (tmr_done && st_reg.pwr != SERP_DEAD)
    begin
      st_next.pwr = SERP_DEAD;
      st_next.relays = '0;
      st_next.dout_float = 1'b1;
      st_next.totalize = 1'b0;
      st_next.active = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      // Only this reset, the line power cycle, clears the battery latch.
      st_reg <= '0;
      st_reg.pwr <= SERP_RUN;
      st_reg.status <= serp_pkg::STATUS_RESET;
      st_reg.dout_float <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign REPORT_DATA_OUT = st_reg.data;
  assign REPORT_VALID_OUT = st_reg.valid;
  assign STATUS_BYTE_OUT = st_reg.status;
  assign STANDBY_OUT = st_reg.pwr != SERP_RUN;
  assign SHUTDOWN_OUT = st_reg.pwr == SERP_DEAD;
  assign SELFTEST_RESET_OUT = st_reg.selftest_rst;
  assign ERROR_LED_OUT = st_reg.lowbat;
  assign RELAY_OUT = st_reg.relays;
  assign DOUT_OUT = st_reg.dout;
  assign DOUT_OE_N_OUT = {DOUT_WIDTH{st_reg.dout_float}};
  assign TOTALIZE_OUT = st_reg.totalize;
endmodule : serp_status_report
`default_nettype wire

/* src/serp_pkg.sv */
// Package for the status, error report and standby block.
// Assumes one 200 MHz clock shared by every user of these constants.
package serp_pkg;
  // Bit positions in the status byte.
  localparam int unsigned ST_READY = 0;
  localparam int unsigned ST_POR = 1;
  localparam int unsigned ST_SELFTEST = 2;
  localparam int unsigned ST_EVENT = 3;
  localparam int unsigned ST_LOWBAT = 4;
  localparam int unsigned ST_ABNORMAL = 5;
  localparam int unsigned ST_SERVICE = 6;
  // Bit positions in the command error flags.
  localparam int unsigned GE_METER_OFF = 0;
  localparam int unsigned GE_TALK_NODATA = 1;
  localparam int unsigned GE_SYNTAX = 2;
  localparam int unsigned GE_WRONG_OPTION = 3;
  localparam int unsigned GE_LOWBAT_CMD = 4;
  localparam int unsigned GE_EMPTY_LIST = 5;
  localparam int unsigned GE_LIST_FULL = 6;
  // Report layout.
  localparam int unsigned REPORT_LEN = 24;
  localparam int unsigned ERROR_REGS = 4;
  localparam int unsigned EXTRA_REGS = 20;
  localparam int unsigned LIST_MAX = 30;
  // Reset values.
  localparam logic [7:0] STATUS_RESET = 8'h02;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Timing of the low-battery shutdown.
  localparam longint unsigned CLK_HZ = 200000000;
  localparam longint unsigned LOWBAT_DELAY_S = 180;
  localparam longint unsigned LOWBAT_CYCLES = CLK_HZ * LOWBAT_DELAY_S;
  // Valid bits of the service mask and of the status byte.
  localparam logic [7:0] STATUS_USED = 8'h7f;
  localparam logic [7:0] MASKABLE = 8'h2f;
endpackage : serp_pkg

/* src/serp_timer.sv */
// Down counter that fires once a given number of cycles after a start.
// Assumes start is a synchronous single-cycle or level request.
`timescale 1ns/10ps
`default_nettype none
module serp_timer #(
  parameter int unsigned WIDTH = 36
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic [WIDTH-1:0] count_in,
  // Result
  output logic running_out,
  output logic done_out
);
  typedef struct packed {
    logic run;
    logic done;
    logic [WIDTH-1:0] cnt;
  } serp_tmr_t;

  serp_tmr_t st_reg;
  serp_tmr_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (start_in && !st_reg.run)
    begin
      st_next.run = 1'b1;
      st_next.cnt = count_in;
    end
    else if (st_reg.run)
    begin
      if (st_reg.cnt <= {{(WIDTH-1){1'b0}}, 1'b1})
      begin
        st_next.run = 1'b0;
        st_next.done = 1'b1;
      end
      else
      begin
        st_next.cnt = st_reg.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign running_out = st_reg.run;
  assign done_out = st_reg.done;
endmodule : serp_timer
`default_nettype wire

/* testbench/serp_status_report_monitor.sv */
// Port checker for the status report and standby block.
// Assumes the shutdown delay is near 20 cycles in simulation.
`timescale 1ns/10ps
`default_nettype none
module serp_status_report_monitor #(
  parameter int unsigned RELAY_WIDTH = 32,
  parameter int unsigned DOUT_WIDTH = 16
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic STANDBY_CMD_IN,
  input wire logic LOOP_ACTIVITY_IN,
  input wire logic LOW_BATTERY_IN,
  input wire logic [7:0] STATUS_BYTE_OUT,
  input wire logic STANDBY_OUT,
  input wire logic SHUTDOWN_OUT,
  input wire logic ERROR_LED_OUT,
  input wire logic [RELAY_WIDTH-1:0] RELAY_OUT,
  input wire logic [DOUT_WIDTH-1:0] DOUT_OE_N_OUT,
  input wire logic TOTALIZE_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence s_idle_standby;
    STANDBY_OUT && !SHUTDOWN_OUT;
  endsequence
  sequence s_battery_hit;
    LOW_BATTERY_IN && !ERROR_LED_OUT;
  endsequence
  a_top_bit_zero: assert property (!STATUS_BYTE_OUT[7])
    else $error("status bit 7 set");
  a_battery_bits: assert property (LOW_BATTERY_IN |=>
    STATUS_BYTE_OUT[6:4] == 3'b111 && ERROR_LED_OUT)
    else $error("low battery bits missing");
  a_battery_sticky: assert property (ERROR_LED_OUT |=>
    ERROR_LED_OUT && STATUS_BYTE_OUT[4]) else $error("battery bit lost");
  a_standby_float: assert property (STANDBY_OUT |->
    &DOUT_OE_N_OUT && !TOTALIZE_OUT) else $error("outputs active");
  a_relays_held: assert property (
    s_idle_standby ##1 s_idle_standby |-> $stable(RELAY_OUT))
    else $error("relays moved in standby");
  a_standby_entry: assert property (
    STANDBY_CMD_IN && !STANDBY_OUT |=> STANDBY_OUT)
    else $error("standby not entered");
  a_wake_traffic: assert property (s_idle_standby ##0
    (LOOP_ACTIVITY_IN && !ERROR_LED_OUT) |=> !STANDBY_OUT)
    else $error("traffic did not wake");
  a_shutdown_delay: assert property (s_battery_hit |=>
    !SHUTDOWN_OUT [*8] ##[1:40] SHUTDOWN_OUT)
    else $error("shutdown timing wrong");
  a_dead_final: assert property (SHUTDOWN_OUT |=>
    SHUTDOWN_OUT && STANDBY_OUT && RELAY_OUT == '0)
    else $error("left shutdown");
endmodule : serp_status_report_monitor
bind serp_status_report serp_status_report_monitor #(
  .RELAY_WIDTH(RELAY_WIDTH), .DOUT_WIDTH(DOUT_WIDTH)) mon_i (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN),
  .STANDBY_CMD_IN(STANDBY_CMD_IN), .LOOP_ACTIVITY_IN(LOOP_ACTIVITY_IN),
  .LOW_BATTERY_IN(LOW_BATTERY_IN), .STATUS_BYTE_OUT(STATUS_BYTE_OUT),
  .STANDBY_OUT(STANDBY_OUT), .SHUTDOWN_OUT(SHUTDOWN_OUT),
  .ERROR_LED_OUT(ERROR_LED_OUT), .RELAY_OUT(RELAY_OUT),
  .DOUT_OE_N_OUT(DOUT_OE_N_OUT), .TOTALIZE_OUT(TOTALIZE_OUT));
`default_nettype wire

/* testbench/serp_loop_ctrl.sv */
// Behavioural loop controller that requests register reports.
// Assumes its task is entered at a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module serp_loop_ctrl (
  input wire logic clk_in,
  input wire logic [7:0] data_in,
  input wire logic valid_in,
  output logic report_cmd_out,
  output logic xfer_out
);
  logic [7:0] got [0:23];
  int n_got;
  initial
  begin
    report_cmd_out = 1'b0;
    xfer_out = 1'b0;
    n_got = 0;
  end
  // Undefined top bits are masked; a stray answer still bumps the count.
  always @(posedge clk_in)
    if (valid_in)
    begin
      got[n_got] <= (n_got == 1 || n_got == 3) ?
        data_in & 8'h7f : data_in;
      n_got <= n_got + 1;
    end
  // A gap of zero gives back-to-back transfers, a larger one a slow host.
  task read_report(input int n, input int gap);
    n_got = 0;
    report_cmd_out = 1'b1;
    @(negedge clk_in);
    report_cmd_out = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      xfer_out = 1'b1;
      @(negedge clk_in);
      if (gap > 0 || k == n - 1)
        xfer_out = 1'b0;
      repeat (gap) @(negedge clk_in);
    end
    repeat (2) @(negedge clk_in);
  endtask : read_report
endmodule : serp_loop_ctrl
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the status report and standby block.
// Assumes a 20 cycle shutdown delay and the loop controller model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rst, poll, sby, wake, act, ill, drs, drc, mon, stf, lowb, totalize_cmd;
  logic rcmd, xfer, rv, sb_o, sd_o, st_o, led, tot_o, st_seen;
  logic [7:0] ce, hw, cal, msk, rd, stat;
  logic [159:0] ex;
  logic [31:0] cfg, rly, rly_o;
  logic [15:0] dcmd, dout, oen;
  int err_count, n_checks;
  serp_status_report #(.SHUTDOWN_CYCLES(20)) serp_status_report_i (
    .SYS_CLK_IN(clk), .RST_IN(rst), .REPORT_REGISTERS_CMD_IN(rcmd),
    .INPUT_TRANSFER_IN(xfer), .STATUS_POLL_CMD_IN(poll),
    .STANDBY_CMD_IN(sby), .WAKE_CMD_IN(wake), .LOOP_ACTIVITY_IN(act),
    .ILLEGAL_CMD_IN(ill), .CMD_ERROR_SET_IN(ce), .HW_FAULT_SET_IN(hw),
    .CAL_FAULT_SET_IN(cal), .DATA_READY_SET_IN(drs),
    .DATA_READY_CLR_IN(drc), .MONITOR_EVENT_IN(mon),
    .SELFTEST_FAIL_IN(stf), .LOW_BATTERY_IN(lowb), .SERVICE_MASK_IN(msk),
    .EXTRA_REGS_IN(ex), .CHANNEL_CONFIG_IN(cfg), .RELAY_CMD_IN(rly),
    .DOUT_CMD_IN(dcmd), .TOTALIZE_CMD_IN(totalize_cmd), .REPORT_DATA_OUT(rd),
    .REPORT_VALID_OUT(rv), .STATUS_BYTE_OUT(stat), .STANDBY_OUT(sb_o),
    .SHUTDOWN_OUT(sd_o), .SELFTEST_RESET_OUT(st_o), .ERROR_LED_OUT(led),
    .RELAY_OUT(rly_o), .DOUT_OUT(dout), .DOUT_OE_N_OUT(oen),
    .TOTALIZE_OUT(tot_o));
  serp_loop_ctrl serp_loop_ctrl_i (.clk_in(clk), .data_in(rd),
    .valid_in(rv), .report_cmd_out(rcmd), .xfer_out(xfer));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
    if (st_o)
      st_seen <= 1'b1;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask : pulse
  task rep(input int n, input int gap);
    serp_loop_ctrl_i.read_report(n, gap);
  endtask : rep
  function automatic logic [7:0] g(input int i);
    return serp_loop_ctrl_i.got[i];
  endfunction : g
  task t_illegal;
    pulse(ill);
    rep(4, 0);
    chk("status", 8'h22, g(0));
    chk("general", 8'h04, g(1));
    chk("hardware", 8'h00, g(2));
    chk("status after", 8'h00, stat & 8'h1f);
    rep(4, 0);
    chk("general again", 8'h00, g(1));
    $display("test illegal done");
  endtask : t_illegal
  task t_partial;
    hw = 8'h81;
    cal = 8'h40;
    @(negedge clk);
    hw = 8'h00;
    cal = 8'h00;
    rep(3, 2);
    chk("abnormal", 8'h20, g(0));
    chk("hardware", 8'h81, g(2));
    rep(4, 0);
    chk("hardware kept", 8'h81, g(2));
    chk("calibration", 8'h40, g(3));
    rep(4, 1);
    chk("hardware gone", 8'h00, g(2));
    $display("test partial done");
  endtask : t_partial
  task t_general;
    for (int b = 0; b < 7; b++)
    begin
      ce = 8'h01 << b;
      @(negedge clk);
      ce = 8'h00;
      rep(4, 0);
      chk("general bit", 8'h01 << b, g(1));
      chk("abnormal", 8'h20, g(0) & 8'h20);
    end
    $display("test general done");
  endtask : t_general
  task t_extra;
    rep(25, 0);
    chk("count", 24, serp_loop_ctrl_i.n_got);
    for (int k = 0; k < 20; k++)
      chk("extra", k + 64, g(4 + k));
    $display("test extra done");
  endtask : t_extra
  task t_status;
    msk = 8'h01;
    pulse(drs);
    @(negedge clk);
    chk("service on", 8'h41, stat);
    pulse(drc);
    @(negedge clk);
    chk("service off", 8'h00, stat);
    msk = 8'h00;
    pulse(mon);
    pulse(stf);
    pulse(poll);
    chk("poll", 8'h04, stat & 8'h0f);
    $display("test status done");
  endtask : t_status
  task t_standby;
    chk("driving", 16'h0000, oen);
    pulse(sby);
    rly = 32'hffff_0000;
    repeat (2) @(negedge clk);
    chk("standby", 1'b1, sb_o);
    chk("float", 16'hffff, oen);
    chk("totalize", 1'b0, tot_o);
    chk("relays", 32'h0000_0f0f, rly_o);
    chk("dout held", 16'h1234, dout);
    pulse(act);
    chk("awake", 1'b0, sb_o);
    chk("totalize back", 1'b1, tot_o);
    chk("no selftest", 1'b0, st_seen);
    pulse(sby);
    cfg = 32'h0000_005a;
    pulse(wake);
    @(negedge clk);
    chk("selftest", 1'b1, st_seen);
    $display("test standby done");
  endtask : t_standby
  task t_lowbat;
    pulse(lowb);
    chk("battery bits", 8'h70, stat & 8'h70);
    chk("indicator", 1'b1, led);
    pulse(poll);
    chk("sticky", 8'h10, stat & 8'h10);
    repeat (30) @(negedge clk);
    chk("shutdown", 1'b1, sd_o);
    chk("relays open", 32'h0, rly_o);
    pulse(wake);
    pulse(act);
    chk("still dead", 1'b1, sd_o);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("alive", 1'b0, sd_o);
    chk("power cycle", serp_pkg::STATUS_RESET, stat);
    $display("test low battery done");
  endtask : t_lowbat
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {clk, poll, sby, wake, act, ill, drs, drc, mon, stf, lowb} = '0;
    {ce, hw, cal, msk, st_seen} = '0;
    {rst, totalize_cmd} = 2'b11;
    cfg = 32'h0000_00a5;
    rly = 32'h0000_0f0f;
    dcmd = 16'h1234;
    {err_count, n_checks} = '0;
    for (int k = 0; k < 20; k++)
      ex[8 * k +: 8] = 8'(k + 64);
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("reset status", serp_pkg::STATUS_RESET, stat);
    t_illegal;
    t_partial;
    t_general;
    t_extra;
    t_status;
    t_standby;
    t_lowbat;
    report_and_stop;
  end
  initial
  begin
    #20000;
    err_count++;
    report_and_stop;
  end
endmodule : testbench
`default_nettype wire
